/* hw/cbo_pkg.sv */
// constants for the clock buffer output enable configuration slave
package cbo_pkg;
    // ----------------------------------------
    // bus addressing
    // ----------------------------------------
    localparam logic [6:0] SLAVE_ADDR = 7'h69;
    localparam int NUM_CFG_BYTES = 3;
    localparam logic [1:0] OFS_ENABLE_LOW = 2'h0;
    localparam logic [1:0] OFS_ENABLE_MID = 2'h1;
    localparam logic [1:0] OFS_ENABLE_HIGH = 2'h2;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_ENABLE_LOW = 8'hff;
    localparam logic [7:0] RST_ENABLE_MID = 8'hff;
    localparam logic [7:0] RST_ENABLE_HIGH = 8'hc0;
    localparam logic [7:0] HIGH_IMPL_MASK = 8'hc0;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int MAX_LOW_HOLD_MS = 10;
    localparam int MAX_LOW_HOLD_CYC = MAX_LOW_HOLD_MS * CLK_MHZ * 1000;
    // ----------------------------------------
    // receiver states
    // ----------------------------------------
    typedef enum logic [2:0] {
        CBO_IDLE,
        CBO_ADDR,
        CBO_ACK,
        CBO_DATA,
        CBO_SKIP
    } cbo_state_t;
endpackage : cbo_pkg

/* hw/cbo_cfg_if.sv */
// write path from the serial receiver into the enable register file
`timescale 1ns/100ps
interface cbo_cfg_if;
    logic wr_en;
    logic [1:0] wr_idx;
    logic [7:0] wr_data;
    logic [23:0] rd_all;
    modport writer (output wr_en, output wr_idx, output wr_data, input rd_all);
    modport store (input wr_en, input wr_idx, input wr_data, output rd_all);
endinterface : cbo_cfg_if

/* hw/cbo_enable_regs.sv */
// three configuration bytes holding the output enables
`timescale 1ns/100ps
module cbo_enable_regs (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // write path
    cbo_cfg_if.store cfg
);
    logic [7:0] mem [cbo_pkg::NUM_CFG_BYTES];
    logic [23:0] rd_q;

    // values held until overwritten, also through power-down
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mem[0] <= cbo_pkg::RST_ENABLE_LOW;
            mem[1] <= cbo_pkg::RST_ENABLE_MID;
            mem[2] <= cbo_pkg::RST_ENABLE_HIGH;
        end else if (cfg.wr_en) begin
            mem[cfg.wr_idx] <= cfg.wr_data;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_q <= {cbo_pkg::RST_ENABLE_HIGH, cbo_pkg::RST_ENABLE_MID, cbo_pkg::RST_ENABLE_LOW};
        end else begin
            rd_q <= {mem[2], mem[1], mem[0]};
        end
    end

    assign cfg.rd_all = rd_q;
endmodule : cbo_enable_regs

/* hw/cbo_config_slave.sv */
// serial write-only configuration slave gating eighteen buffered clocks
// Functional notes
// - answer only address 1101001 with write direction; receiver only.
// - data bytes fill byte 0, then 1, then 2, each transfer.
// - bits arrive most significant first, bit 7 down to 0.
// - transfer valid once the byte count acknowledge is done.
// - command and count contents may be ignored.
// - data beyond count or implemented bytes may be discarded.
// - never hold clock or data low over 10 ms; no stretching.
// - general call need not be acknowledged.
// - standard mode slave, no glitch filter required.
// - in power-down, bus pins released and configuration kept.
// - each register holds the last written value.
// - byte 0 bit n enables output n.
// - byte 1 bit n enables output n plus 8.
// - byte 2 bits 7 and 6 enable outputs 17 and 16.
// - disabled output is held low, no toggling.
`timescale 1ns/100ps
module cbo_config_slave (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // serial bus pins
    input wire logic serial_bus_clock_line_i,
    input wire logic serial_bus_data_line_i,
    output logic serial_bus_data_line_o,
    output logic serial_bus_data_line_oe_b_o,
    output logic serial_bus_clock_line_oe_b_o,
    // power-down pin, active low
    input wire logic low_power_request_n_i,
    // clock path
    input wire logic buf_clk_i,
    output logic [17:0] fanout_clk_o
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic scl_d;
    logic sda_d;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1 <= 4'hf;
            sync2 <= 4'hf;
        end else begin
            sync1 <= {serial_bus_clock_line_i, serial_bus_data_line_i,
                      low_power_request_n_i, buf_clk_i};
            sync2 <= sync1;
        end
    end

    wire scl = sync2[3];
    wire sda = sync2[2];
    wire pwr_dn = !sync2[1];
    wire clk_in = sync2[0];

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end

    // no glitch filter: standard mode only
    wire scl_rise = scl && !scl_d;
    wire scl_fall = !scl && scl_d;
    wire start_cond = scl && scl_d && sda_d && !sda;
    wire stop_cond = scl && scl_d && !sda_d && sda;

    // ----------------------------------------
    // byte receiver
    // ----------------------------------------
    cbo_pkg::cbo_state_t state;
    cbo_pkg::cbo_state_t next_state;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic [5:0] byte_cnt;
    logic ack_drive;
    logic addr_ok;
    logic txn_valid;

    cbo_cfg_if cfg ();

    cbo_enable_regs u_regs (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .cfg(cfg)
    );

    wire byte_done = scl_rise && (bit_cnt == 4'h7);
    wire [7:0] shift_in = {shift[6:0], sda};
    // write only, single address; general call never matches
    wire addr_match = (shift_in == {cbo_pkg::SLAVE_ADDR, 1'b0});
    // command and count bytes skipped without inspection
    wire is_data = (byte_cnt >= 6'h2);
    wire [5:0] data_idx = byte_cnt - 6'h2;
    // bytes past the implemented registers are dropped
    wire in_range = data_idx < 6'(cbo_pkg::NUM_CFG_BYTES);

    assign cfg.wr_en = (state == cbo_pkg::CBO_DATA) && byte_done && addr_ok
                       && txn_valid && is_data && in_range && !pwr_dn;
    assign cfg.wr_idx = data_idx[1:0];
    assign cfg.wr_data = shift_in;

    always_comb begin
        next_state = state;
        unique case (state)
            cbo_pkg::CBO_IDLE: next_state = state;
            cbo_pkg::CBO_ADDR: begin
                if (byte_done) begin
                    next_state = addr_match ? cbo_pkg::CBO_ACK : cbo_pkg::CBO_SKIP;
                end
            end
            cbo_pkg::CBO_ACK: begin
                if (scl_fall && ack_drive) begin
                    next_state = cbo_pkg::CBO_DATA;
                end
            end
            cbo_pkg::CBO_DATA: begin
                if (byte_done) begin
                    next_state = cbo_pkg::CBO_ACK;
                end
            end
            cbo_pkg::CBO_SKIP: next_state = state;
        endcase
        if (start_cond && !pwr_dn) begin
            next_state = cbo_pkg::CBO_ADDR;
        end else if (stop_cond || pwr_dn) begin
            next_state = cbo_pkg::CBO_IDLE;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= cbo_pkg::CBO_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shift <= 8'h00;
            bit_cnt <= 4'h0;
        end else if (start_cond || state == cbo_pkg::CBO_ACK) begin
            bit_cnt <= 4'h0;
        end else if (scl_rise) begin
            shift <= shift_in;
            bit_cnt <= (bit_cnt == 4'h7) ? 4'h0 : bit_cnt + 4'h1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            byte_cnt <= 6'h0;
            addr_ok <= 1'b0;
            txn_valid <= 1'b0;
        end else if (start_cond) begin
            byte_cnt <= 6'h0;
            addr_ok <= 1'b0;
            txn_valid <= 1'b0;
        end else begin
            if (state == cbo_pkg::CBO_ADDR && byte_done) begin
                addr_ok <= addr_match;
            end
            if (state == cbo_pkg::CBO_DATA && byte_done && byte_cnt != 6'h3f) begin
                byte_cnt <= byte_cnt + 6'h1;
            end
            // count byte acknowledged: transfer now valid
            if (state == cbo_pkg::CBO_ACK && scl_fall && ack_drive && byte_cnt == 6'h2) begin
                txn_valid <= 1'b1;
            end
        end
    end

    // ack low only from one falling edge to the next: no stretching
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_drive <= 1'b0;
        end else if (pwr_dn || state != cbo_pkg::CBO_ACK) begin
            ack_drive <= 1'b0;
        end else if (scl_fall) begin
            ack_drive <= !ack_drive;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            serial_bus_data_line_o <= 1'b1;
            serial_bus_data_line_oe_b_o <= 1'b1;
            serial_bus_clock_line_oe_b_o <= 1'b1;
        end else begin
            serial_bus_data_line_o <= 1'b0;
            serial_bus_data_line_oe_b_o <= !ack_drive;
            serial_bus_clock_line_oe_b_o <= 1'b1;
        end
    end

    // ----------------------------------------
    // output gating
    // ----------------------------------------
    logic [17:0] en_live;
    wire [23:0] cfg_bytes = cfg.rd_all;
    // reserved bits of the high byte never reach the gating
    wire [7:0] high_used = cfg_bytes[23:16] & cbo_pkg::HIGH_IMPL_MASK;
    wire [17:0] en_map = {high_used[7], high_used[6], cfg_bytes[15:8], cfg_bytes[7:0]};

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            en_live <= 18'h3ffff;
        end else if (!clk_in) begin
            en_live <= en_map;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fanout_clk_o <= 18'h00000;
        end else begin
            fanout_clk_o <= {18{clk_in}} & en_live;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    localparam int ACK_BOUND = 1000;
    logic [20:0] low_cnt;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            low_cnt <= 21'h0;
        end else begin
            low_cnt <= serial_bus_data_line_oe_b_o ? 21'h0 : low_cnt + 21'h1;
        end
    end

    property p_hold_limit;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        low_cnt < 21'(cbo_pkg::MAX_LOW_HOLD_CYC);
    endproperty
    a_hold_limit: assert property (p_hold_limit) else $error("data held low too long");

    property p_no_stretch;
        @(posedge core_clk_i) disable iff (!rst_b_i) serial_bus_clock_line_oe_b_o;
    endproperty
    a_no_stretch: assert property (p_no_stretch) else $error("clock line stretched");

    property p_disabled_low;
        @(posedge core_clk_i) disable iff (!rst_b_i) (fanout_clk_o & ~en_live) == 18'h0;
    endproperty
    a_disabled_low: assert property (p_disabled_low) else $error("disabled output toggled");

    property p_gate_on_low;
        @(posedge core_clk_i) disable iff (!rst_b_i) $changed(en_live) |-> !$past(clk_in);
    endproperty
    a_gate_on_low: assert property (p_gate_on_low) else $error("enable changed while clock high");

    property p_pd_release;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        pwr_dn [*3] |-> serial_bus_data_line_oe_b_o;
    endproperty
    a_pd_release: assert property (p_pd_release) else $error("bus driven in power-down");

    property p_pd_keep;
        @(posedge core_clk_i) disable iff (!rst_b_i) pwr_dn [*3] |-> $stable(cfg.rd_all);
    endproperty
    a_pd_keep: assert property (p_pd_keep) else $error("write during power-down");

    property p_write_order;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        cfg.wr_en |-> cfg.wr_idx == 2'(byte_cnt - 6'h2) && addr_ok;
    endproperty
    a_write_order: assert property (p_write_order) else $error("write index out of order");

    sequence s_foreign_addr;
        state == cbo_pkg::CBO_ADDR && byte_done && !addr_match;
    endsequence
    property p_addr_only;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        s_foreign_addr |=> !cfg.wr_en throughout (state == cbo_pkg::CBO_SKIP) [*4];
    endproperty
    a_addr_only: assert property (p_addr_only) else $error("foreign address accepted");

    property p_ack_bounded;
        @(posedge core_clk_i) disable iff (!rst_b_i)
        $rose(ack_drive) |-> ##[1:ACK_BOUND] !ack_drive || pwr_dn || state != cbo_pkg::CBO_ACK;
    endproperty
    a_ack_bounded: assert property (p_ack_bounded) else $error("ack held too long");
endmodule : cbo_config_slave

/* verification/cbo_bus_ctrl.sv */
// behavioural two-wire bus controller that issues block writes
`timescale 1ns/100ps
module cbo_bus_ctrl (
    // clock used to pace the bus
    input wire logic core_clk_i,
    // resolved data wire
    input wire logic sda_wire_i,
    // controller pull levels, 1 = released
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask : wait_cyc
    // ----------------------------------------
    // bus clock of 80 ns, data bits move only while clock is low
    // ----------------------------------------
    task automatic put_bit(input logic b, output logic seen);
        wait_cyc(2);
        sda_o = b;
        wait_cyc(3);
        scl_o = 1'b1;
        wait_cyc(5);
        seen = sda_wire_i;
        scl_o = 1'b0;
    endtask : put_bit
    task automatic put_byte(input logic [7:0] v, inout int acks);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(v[i], s);
        end
        put_bit(1'b1, s);
        if (s === 1'b0) begin
            acks++;
        end
    endtask : put_byte
    // also serves as repeated start when the clock is low
    task automatic start_cond();
        wait_cyc(2);
        sda_o = 1'b1;
        wait_cyc(3);
        scl_o = 1'b1;
        wait_cyc(5);
        sda_o = 1'b0;
        wait_cyc(5);
        scl_o = 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        wait_cyc(2);
        sda_o = 1'b0;
        wait_cyc(3);
        scl_o = 1'b1;
        wait_cyc(5);
        sda_o = 1'b1;
        wait_cyc(5);
    endtask : stop_cond
    // ----------------------------------------
    // block write: address, command, count, data bytes from byte 0
    // ----------------------------------------
    task automatic block_write(input logic [6:0] addr, input logic rw, input int n,
                               input logic [23:0] data, input logic do_stop,
                               output int acks);
        acks = 0;
        start_cond();
        put_byte({addr, rw}, acks);
        put_byte(8'h00, acks);
        put_byte(8'(n), acks);
        for (int i = 0; i < n; i++) begin
            put_byte(data[8*i +: 8], acks);
        end
        if (do_stop) begin
            stop_cond();
        end
    endtask : block_write
endmodule : cbo_bus_ctrl

/* verification/test_cbo_config_slave.sv */
// self-checking bench for the output enable configuration slave
`timescale 1ns/100ps
module test_cbo_config_slave;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic buf_clk = 1'b0;
    logic low_power_request_n = 1'b1;
    logic ctl_scl;
    logic ctl_sda;
    logic dev_sda;
    logic dev_sda_oe_b;
    logic dev_scl_oe_b;
    logic [17:0] fanout_clk;
    logic stretch_seen = 1'b0;
    logic [17:0] en_exp;
    wire logic scl_wire = ctl_scl & dev_scl_oe_b;
    wire logic sda_wire = ctl_sda & (dev_sda_oe_b | dev_sda);
    int fails = 0;
    int cmp_count = 0;

    cbo_config_slave cbo_config_slave_i (
        .core_clk_i(core_clk),
        .rst_b_i(rst_b),
        .serial_bus_clock_line_i(scl_wire),
        .serial_bus_data_line_i(sda_wire),
        .serial_bus_data_line_o(dev_sda),
        .serial_bus_data_line_oe_b_o(dev_sda_oe_b),
        .serial_bus_clock_line_oe_b_o(dev_scl_oe_b),
        .low_power_request_n_i(low_power_request_n),
        .buf_clk_i(buf_clk),
        .fanout_clk_o(fanout_clk)
    );
    cbo_bus_ctrl cbo_bus_ctrl_i (
        .core_clk_i(core_clk),
        .sda_wire_i(sda_wire),
        .scl_o(ctl_scl),
        .sda_o(ctl_sda)
    );
    // ----------------------------------------
    // clocks and monitors
    // ----------------------------------------
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        forever begin
            repeat (20) @(negedge core_clk);
            buf_clk = ~buf_clk;
        end
    end
    always @(negedge core_clk) begin
        if (rst_b && dev_scl_oe_b !== 1'b1) begin
            stretch_seen = 1'b1;
        end
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic chk_outputs();
        @(posedge buf_clk);
        repeat (8) @(negedge core_clk);
        check("fanout while input high", {6'h00, fanout_clk}, {6'h00, en_exp});
        @(negedge buf_clk);
        repeat (8) @(negedge core_clk);
        check("fanout while input low", {6'h00, fanout_clk}, 24'h000000);
    endtask : chk_outputs
    task automatic do_write(input logic [6:0] addr, input logic rw, input int n,
                            input logic [23:0] data, input logic do_stop, input int exp_acks);
        int acks;
        cbo_bus_ctrl_i.block_write(addr, rw, n, data, do_stop, acks);
        check("ack count", 24'(acks), 24'(exp_acks));
    endtask : do_write
    task automatic test_done();
        if (fails == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        en_exp = 18'h3ffff;
        chk_outputs();
    endtask : t_reset
    task automatic t_full();
        do_write(cbo_pkg::SLAVE_ADDR, 1'b0, 3, 24'h803ca5, 1'b1, 6);
        en_exp = {2'b10, 8'h3c, 8'ha5};
        chk_outputs();
    endtask : t_full
    task automatic t_partial();
        do_write(cbo_pkg::SLAVE_ADDR, 1'b0, 1, 24'h00000f, 1'b1, 4);
        en_exp[7:0] = 8'h0f;
        chk_outputs();
    endtask : t_partial
    task automatic t_refused();
        logic [7:0] frames [4] = '{8'hd0, 8'hd3, 8'h00, 8'h52};
        foreach (frames[i]) begin
            do_write(frames[i][7:1], frames[i][0], 1, 24'h000000, 1'b1, 0);
        end
        chk_outputs();
    endtask : t_refused
    task automatic t_restart();
        do_write(cbo_pkg::SLAVE_ADDR, 1'b0, 1, 24'h000055, 1'b0, 4);
        do_write(cbo_pkg::SLAVE_ADDR, 1'b0, 2, 24'h0011f0, 1'b1, 5);
        en_exp[15:0] = 16'h11f0;
        chk_outputs();
    endtask : t_restart
    task automatic t_power_down();
        low_power_request_n = 1'b0;
        repeat (10) @(negedge core_clk);
        do_write(cbo_pkg::SLAVE_ADDR, 1'b0, 3, 24'h000000, 1'b1, 0);
        low_power_request_n = 1'b1;
        repeat (10) @(negedge core_clk);
        chk_outputs();
    endtask : t_power_down
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (20) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (5) @(negedge core_clk);
        t_reset();
        t_full();
        t_partial();
        t_refused();
        t_restart();
        t_power_down();
        check("clock stretch seen", {23'h000000, stretch_seen}, 24'h000000);
        test_done();
    end
    initial begin
        #200_000;
        fails++;
        test_done();
    end
endmodule : test_cbo_config_slave
